// file: aio_trigger_ctrl.sv
// Alarm input, relay output, preset and auxiliary port event logic.
// Assumes all inputs are synchronous to REF_CLK and setup ports are steady.
`timescale 1ns/10ps
module aio_trigger_ctrl #(
  parameter int SEC_CYCLES = aio_pkg::AIO_SEC_CYC,
  parameter int WG_GAP_CYCLES = aio_pkg::AIO_WG_GAP_CYC
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Alarm inputs
  input wire logic [3:0] ALARM_IN,
  input wire logic MON_EN,
  input wire aio_pkg::aio_in_cfg_s [3:0] IN_CFG,
  // Relay outputs and alarm sources
  input wire aio_pkg::aio_out_cfg_s [3:0] OUT_CFG,
  input wire logic [3:0] VIDEO_LOSS,
  input wire logic [3:0] TAMPER,
  input wire logic WRITE_ERR,
  input wire logic STORAGE_FULL,
  output logic [3:0] RELAY_OUT,
  // Recording requests
  output logic [3:0] REC_START,
  // Camera link commands
  input wire aio_pkg::aio_cam_cfg_s [3:0] CAM_CFG,
  output aio_pkg::aio_ptz_cmd_s PTZ_CMD,
  // Auxiliary port selection
  input wire aio_pkg::aio_aux_e AUX_MODE,
  // GPS receiver
  input wire logic GPS_BAUD_SLOW,
  input wire logic [4:0] GPS_INTERVAL,
  input wire logic GPS_RXD,
  output logic [7:0] GPS_BYTE,
  output logic GPS_BYTE_VLD,
  output logic GPS_WINDOW,
  // Card reader
  input wire logic WIEG_D0_N,
  input wire logic WIEG_D1_N,
  input wire logic [3:0] WIEG_REC_MASK,
  input wire logic CARD_FWD_EN,
  output logic CARD_VALID,
  output logic CARD_LEN37,
  output logic [34:0] CARD_NUM,
  output logic CARD_FWD
);
  aio_pkg::aio_state_s st_reg; // Registered state
  aio_pkg::aio_state_s st_next; // Next state
  logic [3:0] in_act; // Qualified active input level
  logic [3:0] in_rise; // Input became active
  logic [3:0] in_trig; // Input's contribution to relays
  logic [3:0] src_lvl; // Combined trigger per relay
  logic [3:0] src_rise; // Trigger edge per relay
  logic [3:0] rly_gnd; // Relay idles grounded
  logic [5:0] pls_len; // Clamped pulse length
  logic [4:0] gps_iv; // Clamped GPS interval
  logic [11:0] bit_cyc; // Cycles per serial bit
  logic gps_on; // Aux port serves GPS
  logic wg_on; // Aux port serves the reader
  logic wg_f0; // Reader zero pulse seen
  logic wg_f1; // Reader one pulse seen
  logic issued; // A command already went out this cycle

  // All next-state logic
  always_comb
  begin
    st_next = st_reg;
    st_next.rec = 4'h0;
    st_next.ptz.valid = 1'b0;
    st_next.gvld = 1'b0;
    st_next.cvld = 1'b0;
    st_next.cfwd = 1'b0;
    issued = 1'b0;
    pls_len = 6'h00;
    // Free second tick; long, so its length is a parameter
    st_next.sec_tick = 1'b0;
    if (st_reg.sec_cnt == 24'(SEC_CYCLES - 1))
    begin
      st_next.sec_cnt = 24'h000000;
      st_next.sec_tick = 1'b1;
    end
    else
      st_next.sec_cnt = st_reg.sec_cnt + 24'h000001;

    // Input qualification and edges
    for (int i = 0; i < 4; i++)
    begin
      in_act[i] = IN_CFG[i].en & MON_EN & (ALARM_IN[i] ^ IN_CFG[i].idle_gnd);
      in_rise[i] = in_act[i] & ~st_reg.in_prev[i];
      in_trig[i] = IN_CFG[i].latch ? in_rise[i] : in_act[i];
      if (in_rise[i])
        st_next.rec = st_next.rec | IN_CFG[i].rec_mask;
    end
    st_next.in_prev = in_act;

    // Relay drive per output
    for (int j = 0; j < 4; j++)
    begin
      src_lvl[j] = 1'b0;
      for (int i = 0; i < 4; i++)
        src_lvl[j] = src_lvl[j] | (in_trig[i] & IN_CFG[i].rly_mask[j]);
      src_lvl[j] = src_lvl[j] | (|(VIDEO_LOSS & OUT_CFG[j].vloss_sel))
        | (|(TAMPER & OUT_CFG[j].tamper_sel))
        | (WRITE_ERR & OUT_CFG[j].wr_err_sel) | (STORAGE_FULL & OUT_CFG[j].full_sel);
      src_rise[j] = src_lvl[j] & ~st_reg.src_prev[j];
      // Out-of-range lengths are clamped rather than rejected
      pls_len = OUT_CFG[j].pulse_sec;
      if (pls_len < aio_pkg::AIO_PULSE_MIN)
        pls_len = aio_pkg::AIO_PULSE_MIN;
      else if (pls_len > aio_pkg::AIO_PULSE_MAX)
        pls_len = aio_pkg::AIO_PULSE_MAX;
      rly_gnd[j] = 1'b0;
      case (OUT_CFG[j].mode)
        // Plain level follows the trigger
        aio_pkg::AIO_OUT_OPEN, aio_pkg::AIO_OUT_GND:
        begin
          st_next.rly_on[j] = src_lvl[j];
          rly_gnd[j] = (OUT_CFG[j].mode == aio_pkg::AIO_OUT_GND);
        end
        // Toggle flips on each new trigger
        aio_pkg::AIO_TOG_OPEN, aio_pkg::AIO_TOG_GND:
        begin
          if (src_rise[j])
            st_next.rly_on[j] = ~st_reg.rly_on[j];
          rly_gnd[j] = (OUT_CFG[j].mode == aio_pkg::AIO_TOG_GND);
        end
        // Pulse counts whole seconds; tick phase makes it up to one second longer
        aio_pkg::AIO_PLS_OPEN, aio_pkg::AIO_PLS_GND:
        begin
          if (src_rise[j])
          begin
            st_next.rly_on[j] = 1'b1;
            st_next.pls_cnt[j] = pls_len;
          end
          else if (st_reg.sec_tick && st_reg.rly_on[j])
          begin
            if (st_reg.pls_cnt[j] == 6'h00)
              st_next.rly_on[j] = 1'b0;
            else
              st_next.pls_cnt[j] = st_reg.pls_cnt[j] - 6'h01;
          end
          rly_gnd[j] = (OUT_CFG[j].mode == aio_pkg::AIO_PLS_GND);
        end
        // Unknown code keeps the relay idle
        default:
          st_next.rly_on[j] = 1'b0;
      endcase
      // Disabled relay rests idle
      if (!OUT_CFG[j].en)
      begin
        st_next.rly_on[j] = 1'b0;
        st_next.pls_cnt[j] = 6'h00;
      end
      st_next.rly_out[j] = st_next.rly_on[j] ^ rly_gnd[j];
    end
    st_next.src_prev = src_lvl;

    // Preset moves and hold timers
    for (int i = 0; i < 4; i++)
    begin
      if (st_reg.sec_tick && st_reg.hold_run[i])
      begin
        if (st_reg.hold_cnt[i] == 8'h00)
        begin
          st_next.hold_run[i] = 1'b0;
          st_next.pend_off[i] = 1'b1;
        end
        else
          st_next.hold_cnt[i] = st_reg.hold_cnt[i] - 8'h01;
      end
    end
    // Lowest input first, one command per cycle; on-move before off-move
    for (int i = 0; i < 4; i++)
    begin
      if (!issued && (st_reg.pend_on[i] || st_reg.pend_off[i]))
      begin
        issued = 1'b1;
        st_next.ptz.valid = 1'b1;
        st_next.ptz.cam = IN_CFG[i].cam;
        st_next.ptz.link = CAM_CFG[IN_CFG[i].cam];
        if (st_reg.pend_on[i])
        begin
          st_next.ptz.preset = IN_CFG[i].on_preset;
          st_next.pend_on[i] = 1'b0;
        end
        else
        begin
          st_next.ptz.preset = IN_CFG[i].off_preset;
          st_next.pend_off[i] = 1'b0;
        end
      end
    end
    // New edges come last so they win over a same-cycle clear
    for (int i = 0; i < 4; i++)
    begin
      if (IN_CFG[i].ptz_en && in_rise[i])
      begin
        st_next.pend_on[i] = 1'b1;
        st_next.pend_off[i] = 1'b0;
        st_next.hold_run[i] = 1'b0;
      end
      else if (IN_CFG[i].ptz_en && st_reg.in_prev[i] && !in_act[i])
      begin
        st_next.hold_run[i] = 1'b1;
        st_next.hold_cnt[i] = IN_CFG[i].hold_sec;
      end
    end

    // Aux port: one function at a time
    gps_on = (AUX_MODE == aio_pkg::AIO_AUX_GPS);
    wg_on = (AUX_MODE == aio_pkg::AIO_AUX_WIEG);
    bit_cyc = GPS_BAUD_SLOW ? aio_pkg::AIO_BIT_SLOW : aio_pkg::AIO_BIT_FAST;
    gps_iv = GPS_INTERVAL;
    if (gps_iv < aio_pkg::AIO_GPS_MIN)
      gps_iv = aio_pkg::AIO_GPS_MIN;
    else if (gps_iv > aio_pkg::AIO_GPS_MAX)
      gps_iv = aio_pkg::AIO_GPS_MAX;

    // Serial receiver, 8N1, sampled mid-bit
    case (st_reg.ust)
      aio_pkg::AIO_U_IDLE:
      begin
        if (gps_on && !GPS_RXD)
        begin
          st_next.ust = aio_pkg::AIO_U_START;
          st_next.ucnt = {1'b0, bit_cyc[11:1]};
        end
      end
      aio_pkg::AIO_U_START:
      begin
        if (st_reg.ucnt != 12'h000)
          st_next.ucnt = st_reg.ucnt - 12'h001;
        else if (!GPS_RXD)
        begin
          st_next.ust = aio_pkg::AIO_U_DATA;
          st_next.ucnt = bit_cyc - 12'h001;
          st_next.ubit = 3'h0;
        end
        else
          st_next.ust = aio_pkg::AIO_U_IDLE; // Glitch, not a start bit
      end
      aio_pkg::AIO_U_DATA:
      begin
        if (st_reg.ucnt != 12'h000)
          st_next.ucnt = st_reg.ucnt - 12'h001;
        else
        begin
          st_next.ushf = {GPS_RXD, st_reg.ushf[7:1]};
          st_next.ucnt = bit_cyc - 12'h001;
          st_next.ubit = st_reg.ubit + 3'h1;
          if (st_reg.ubit == 3'h7)
            st_next.ust = aio_pkg::AIO_U_STOP;
        end
      end
      aio_pkg::AIO_U_STOP:
      begin
        if (st_reg.ucnt != 12'h000)
          st_next.ucnt = st_reg.ucnt - 12'h001;
        else
        begin
          st_next.ust = aio_pkg::AIO_U_IDLE;
          // Bad stop bit drops the byte
          if (GPS_RXD && st_reg.gwin && gps_on)
          begin
            st_next.gbyte = st_reg.ushf;
            st_next.gvld = 1'b1;
            if (st_reg.ushf == aio_pkg::AIO_GPS_EOL)
              st_next.gwin = 1'b0;
          end
        end
      end
      default:
        st_next.ust = aio_pkg::AIO_U_IDLE;
    endcase
    // Capture window reopens each interval; opening wins over closing
    if (!gps_on)
    begin
      st_next.gwin = 1'b0;
      st_next.gsec = 5'h00;
    end
    else if (st_reg.sec_tick)
    begin
      if (st_reg.gsec + 5'h01 >= gps_iv)
      begin
        st_next.gsec = 5'h00;
        st_next.gwin = 1'b1;
      end
      else
        st_next.gsec = st_reg.gsec + 5'h01;
    end

    // Reader frame collection; lines pulse low
    wg_f0 = wg_on & st_reg.wd0_prev & ~WIEG_D0_N;
    wg_f1 = wg_on & st_reg.wd1_prev & ~WIEG_D1_N;
    st_next.wd0_prev = WIEG_D0_N;
    st_next.wd1_prev = WIEG_D1_N;
    if (!wg_on)
    begin
      st_next.wcnt = 6'h00;
      st_next.wgap = 18'h00000;
    end
    else if (wg_f0 || wg_f1)
    begin
      st_next.wshf = {st_reg.wshf[35:0], wg_f1};
      st_next.wgap = 18'h00000;
      if (st_reg.wcnt != aio_pkg::AIO_WG_SAT)
        st_next.wcnt = st_reg.wcnt + 6'h01;
    end
    else if (st_reg.wcnt != 6'h00)
    begin
      if (st_reg.wgap == 18'(WG_GAP_CYCLES - 1))
      begin
        // Frame closed by idle gap; other lengths are discarded
        st_next.wcnt = 6'h00;
        st_next.wgap = 18'h00000;
        if (st_reg.wcnt == aio_pkg::AIO_WG_LEN26 || st_reg.wcnt == aio_pkg::AIO_WG_LEN37)
        begin
          st_next.cvld = 1'b1;
          st_next.clen37 = (st_reg.wcnt == aio_pkg::AIO_WG_LEN37);
          // Parity bits at both ends are stripped, not checked
          st_next.cnum = st_next.clen37 ? st_reg.wshf[35:1] : {11'h000, st_reg.wshf[24:1]};
          st_next.cfwd = CARD_FWD_EN;
          if (MON_EN)
            st_next.rec = st_next.rec | WIEG_REC_MASK;
        end
      end
      else
        st_next.wgap = st_reg.wgap + 18'h00001;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // Outputs straight from the state register
  assign RELAY_OUT = st_reg.rly_out;
  assign REC_START = st_reg.rec;
  assign PTZ_CMD = st_reg.ptz;
  assign GPS_BYTE = st_reg.gbyte;
  assign GPS_BYTE_VLD = st_reg.gvld;
  assign GPS_WINDOW = st_reg.gwin;
  assign CARD_VALID = st_reg.cvld;
  assign CARD_LEN37 = st_reg.clen37;
  assign CARD_NUM = st_reg.cnum;
  assign CARD_FWD = st_reg.cfwd;

  // Checks on the registered behaviour
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_pls_fire;
    OUT_CFG[0].en && OUT_CFG[0].mode == aio_pkg::AIO_PLS_OPEN && src_rise[0];
  endsequence
  sequence s_on_two;
    st_reg.rly_on[0] [*2];
  endsequence

  chk_rec_on_edge: assert property (in_rise[0] |=> (REC_START & $past(IN_CFG[0].rec_mask)) == $past(IN_CFG[0].rec_mask))
    else $error("record request missing on input edge");
  chk_mon_idle: assert property (!MON_EN |=> REC_START == 4'h0)
    else $error("record request while monitoring stopped");
  chk_rly_disabled: assert property (!OUT_CFG[0].en && OUT_CFG[0].mode == aio_pkg::AIO_OUT_GND |=> RELAY_OUT[0])
    else $error("disabled grounded relay not idle");
  chk_toggle_flip: assert property (OUT_CFG[0].en && OUT_CFG[0].mode == aio_pkg::AIO_TOG_OPEN && src_rise[0] |=> RELAY_OUT[0] != $past(RELAY_OUT[0]))
    else $error("toggle relay did not flip");
  chk_pulse_start: assert property (s_pls_fire |=> s_on_two)
    else $error("pulse relay not held on");
  chk_pulse_bound: assert property (st_reg.pls_cnt[0] <= aio_pkg::AIO_PULSE_MAX)
    else $error("pulse count above limit");
  chk_latch_brief: assert property (IN_CFG[0].latch && in_rise[0] ##1 in_act[0] |-> !in_trig[0])
    else $error("latched input followed its level");
  chk_card_len: assert property (CARD_VALID |-> $past(st_reg.wcnt) == (CARD_LEN37 ? aio_pkg::AIO_WG_LEN37 : aio_pkg::AIO_WG_LEN26))
    else $error("card accepted with wrong length");
  chk_gps_excl: assert property (GPS_BYTE_VLD |-> $past(AUX_MODE) == aio_pkg::AIO_AUX_GPS)
    else $error("gps byte while port not in gps use");
  chk_preset_cmd: assert property ((IN_CFG[0].ptz_en && in_rise[0]) ||
    (IN_CFG[1].ptz_en && in_rise[1]) |-> ##[1:5] PTZ_CMD.valid)
    else $error("preset command not sent");
endmodule

// file: aio_pkg.sv
// Constants, modes and carrier structs for the alarm I/O trigger controller.
// Assumes a single 10 MHz clock; every user of it names items as aio_pkg::x.
package aio_pkg;
  // Clock rate and time figures
  localparam int AIO_CLK_HZ = 10000000;
  localparam int AIO_TICK_S = 1; // Base second for pulse, hold, GPS timing
  localparam int AIO_SEC_CYC = AIO_TICK_S * AIO_CLK_HZ;
  localparam int AIO_WG_GAP_US = 20000; // Wiegand idle gap closing a frame
  localparam int AIO_WG_GAP_CYC = AIO_WG_GAP_US * (AIO_CLK_HZ / 1000000);
  localparam int AIO_BAUD_FAST = 9600;
  localparam int AIO_BAUD_SLOW = 4800;
  localparam logic [11:0] AIO_BIT_FAST = 12'(AIO_CLK_HZ / AIO_BAUD_FAST);
  localparam logic [11:0] AIO_BIT_SLOW = 12'(AIO_CLK_HZ / AIO_BAUD_SLOW);
  // Limits and frame lengths
  localparam logic [5:0] AIO_PULSE_MIN = 6'h01;
  localparam logic [5:0] AIO_PULSE_MAX = 6'h3c;
  localparam logic [4:0] AIO_GPS_MIN = 5'h01;
  localparam logic [4:0] AIO_GPS_MAX = 5'h1e;
  localparam logic [5:0] AIO_WG_LEN26 = 6'h1a;
  localparam logic [5:0] AIO_WG_LEN37 = 6'h25;
  localparam logic [5:0] AIO_WG_SAT = 6'h3f;
  localparam logic [7:0] AIO_GPS_EOL = 8'h0a; // Line feed ends one sentence

  // Relay drive modes
  typedef enum logic [2:0] {
    AIO_OUT_OPEN, AIO_OUT_GND, AIO_TOG_OPEN, AIO_TOG_GND, AIO_PLS_OPEN, AIO_PLS_GND
  } aio_mode_e;
  // Shared auxiliary port use
  typedef enum logic [1:0] {AIO_AUX_OFF, AIO_AUX_GPS, AIO_AUX_WIEG} aio_aux_e;
  // Serial receiver states
  typedef enum logic [1:0] {AIO_U_IDLE, AIO_U_START, AIO_U_DATA, AIO_U_STOP} aio_uart_e;

  // Per-input setup
  typedef struct packed {
    logic en;
    logic idle_gnd; // Idle level is grounded
    logic latch;
    logic [3:0] rly_mask;
    logic [3:0] rec_mask;
    logic ptz_en;
    logic [1:0] cam;
    logic [7:0] on_preset;
    logic [7:0] off_preset;
    logic [7:0] hold_sec;
  } aio_in_cfg_s;
  // Per-relay setup
  typedef struct packed {
    logic en;
    aio_mode_e mode;
    logic [5:0] pulse_sec;
    logic [3:0] vloss_sel;
    logic [3:0] tamper_sel;
    logic wr_err_sel;
    logic full_sel;
  } aio_out_cfg_s;
  // Per-camera link settings
  typedef struct packed {
    logic [1:0] proto;
    logic [2:0] baud;
    logic [5:0] speed;
    logic [7:0] addr;
  } aio_cam_cfg_s;
  // Preset move command
  typedef struct packed {
    logic valid;
    logic [1:0] cam;
    aio_cam_cfg_s link;
    logic [7:0] preset;
  } aio_ptz_cmd_s;

  // Whole state of the controller
  typedef struct packed {
    logic [3:0] in_prev;
    logic [3:0] src_prev;
    logic [3:0] rly_on;
    logic [3:0][5:0] pls_cnt;
    logic [3:0] rly_out;
    logic [23:0] sec_cnt;
    logic sec_tick;
    logic [3:0] hold_run;
    logic [3:0][7:0] hold_cnt;
    logic [3:0] pend_on;
    logic [3:0] pend_off;
    aio_ptz_cmd_s ptz;
    logic [3:0] rec;
    aio_uart_e ust;
    logic [11:0] ucnt;
    logic [2:0] ubit;
    logic [7:0] ushf;
    logic [7:0] gbyte;
    logic gvld;
    logic [4:0] gsec;
    logic gwin;
    logic wd0_prev;
    logic wd1_prev;
    logic [36:0] wshf;
    logic [5:0] wcnt;
    logic [17:0] wgap;
    logic cvld;
    logic clen37;
    logic [34:0] cnum;
    logic cfwd;
  } aio_state_s;
endpackage

// file: aio_partner.sv
// Far-side model: card reader lines and GPS serial transmitter.
// Assumes the caller starts each task just after a falling clock edge.
`timescale 1ns/10ps
module aio_partner (
  // Clock
  input wire logic ref_clk,
  // Reader lines, pulled up when idle
  output logic wieg_d0_n,
  output logic wieg_d1_n,
  // GPS serial line, idle high
  output logic gps_rxd
);
  // Lines rest at their pull-up level
  initial
  begin
    wieg_d0_n = 1'b1;
    wieg_d1_n = 1'b1;
    gps_rxd = 1'b1;
  end

  // One frame, first bit first; low 2 cycles, high 3, well inside the gap
  task automatic send_card(input logic [36:0] bits, input int len);
    for (int i = len - 1; i >= 0; i--)
    begin
      if (bits[i])
        wieg_d1_n = 1'b0;
      else
        wieg_d0_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      wieg_d0_n = 1'b1;
      wieg_d1_n = 1'b1;
      repeat (3) @(negedge ref_clk);
    end
  endtask

  // One 8N1 byte, low bit first, at the given bit time
  task automatic send_byte(input logic [7:0] b, input int bit_cyc);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      gps_rxd = frame[i];
      repeat (bit_cyc) @(negedge ref_clk);
    end
  endtask
endmodule

// file: test_aio_trigger_ctrl.sv
// Self-checking bench for the alarm I/O trigger controller.
// Assumes a short second (20 cycles) and a short reader gap (8 cycles).
`timescale 1ns/10ps
`define CMP(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module test_aio_trigger_ctrl;
  localparam int SEC = 20; // Shortened second
  // Clock, reset, counters, seed
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h00010721;
  // Design inputs
  logic [3:0] alarm_in, video_loss, tamper, wieg_rec_mask;
  logic mon_en, write_err, storage_full, gps_baud_slow, card_fwd_en;
  logic [4:0] gps_interval;
  aio_pkg::aio_in_cfg_s [3:0] in_cfg;
  aio_pkg::aio_out_cfg_s [3:0] out_cfg;
  aio_pkg::aio_cam_cfg_s [3:0] cam_cfg;
  aio_pkg::aio_aux_e aux_mode;
  wire logic wd0_n, wd1_n, gps_rxd;
  // Design outputs
  logic [3:0] relay_out, rec_start;
  aio_pkg::aio_ptz_cmd_s ptz_cmd;
  logic [7:0] gps_byte;
  logic gps_byte_vld, gps_window, card_valid, card_len37, card_fwd;
  logic [34:0] card_num;
  // Scenario state
  logic [3:0] rec_acc = 4'h0; // Every recording pulse since last clear
  logic win_after, fwd_at, seen, act;
  logic [2:0] mm;
  logic [36:0] bits;
  logic [7:0] on_p, off_p;
  logic [1:0] c;
  int k, j, n, eff, lens[4];

  always #50 ref_clk = ~ref_clk;
  // Pulses are gathered so their exact cycle does not matter
  always @(posedge ref_clk) rec_acc <= rec_acc | rec_start;

  aio_trigger_ctrl #(.SEC_CYCLES(SEC), .WG_GAP_CYCLES(8)) aio_trigger_ctrl_inst (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .ALARM_IN(alarm_in), .MON_EN(mon_en),
    .IN_CFG(in_cfg), .OUT_CFG(out_cfg), .VIDEO_LOSS(video_loss), .TAMPER(tamper),
    .WRITE_ERR(write_err), .STORAGE_FULL(storage_full), .RELAY_OUT(relay_out),
    .REC_START(rec_start), .CAM_CFG(cam_cfg), .PTZ_CMD(ptz_cmd), .AUX_MODE(aux_mode),
    .GPS_BAUD_SLOW(gps_baud_slow), .GPS_INTERVAL(gps_interval), .GPS_RXD(gps_rxd),
    .GPS_BYTE(gps_byte), .GPS_BYTE_VLD(gps_byte_vld), .GPS_WINDOW(gps_window),
    .WIEG_D0_N(wd0_n), .WIEG_D1_N(wd1_n), .WIEG_REC_MASK(wieg_rec_mask),
    .CARD_FWD_EN(card_fwd_en), .CARD_VALID(card_valid), .CARD_LEN37(card_len37),
    .CARD_NUM(card_num), .CARD_FWD(card_fwd));
  aio_partner aio_partner_inst (.ref_clk(ref_clk), .wieg_d0_n(wd0_n), .wieg_d1_n(wd1_n),
    .gps_rxd(gps_rxd));

  // Next LFSR value
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // Card number: frame without its two parity bits
  function automatic logic [34:0] exp_num(input logic [36:0] b, input int len);
    return 35'((b >> 1) & ((37'h1 << (len - 2)) - 37'h1));
  endfunction
  // Watched event by selector
  function automatic logic hit(input int s);
    case (s)
      1: return ptz_cmd.valid;
      2: return gps_byte_vld;
      3: return card_valid;
      default: return gps_window;
    endcase
  endfunction

  task automatic tick(input int cyc);
    repeat (cyc) @(negedge ref_clk);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bounded wait; a required event that never comes ends the run
  task automatic watch(input int s, input int bound, input logic must, output int cnt);
    seen = 1'b0;
    for (cnt = 0; cnt < bound && !seen; cnt++)
    begin
      @(negedge ref_clk);
      seen = (hit(s) === 1'b1);
    end
    fwd_at = card_fwd; // Pulse captured while it stands
    if (seen)
    begin
      tick(1);
      win_after = gps_window;
    end
    else if (must)
    begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  // GPS byte through the partner, watching for its valid pulse
  task automatic gps(input logic [7:0] b);
    int bc;
    bc = gps_baud_slow ? aio_pkg::AIO_BIT_SLOW : aio_pkg::AIO_BIT_FAST;
    fork
      aio_partner_inst.send_byte(b, bc);
      watch(2, 11 * bc, 1'b0, n);
    join
  endtask
  // Input 0 to a level, then settle
  task automatic drive0(input logic v, input int cyc);
    alarm_in[0] = v;
    tick(cyc);
  endtask

  initial
  begin
    {alarm_in, video_loss, tamper, write_err, storage_full, gps_baud_slow} = '0;
    {in_cfg, out_cfg, card_fwd_en} = '0;
    cam_cfg = 76'({rnd(), rnd(), rnd()});
    aux_mode = aio_pkg::AIO_AUX_OFF;
    gps_interval = 5'h1e;
    wieg_rec_mask = 4'(rnd());
    mon_en = 1'b1;
    tick(6);
    `CMP(relay_out, 4'h0)
    sys_rst = 1'b0;
    k = 0; // Relay 0, where the design's own checks look
    in_cfg[0].en = 1'b1;
    in_cfg[0].rly_mask = 4'(1 << k);
    in_cfg[0].rec_mask = 4'(rnd()) | 4'h1;
    // Every drive mode: disabled rest, idle level, trigger, release
    for (int m = 0; m < 6; m++)
    begin
      mm = 3'(m);
      act = ~mm[0];
      out_cfg[k] = '0;
      out_cfg[k].mode = aio_pkg::aio_mode_e'(mm);
      out_cfg[k].pulse_sec = 6'(rnd() % 3);
      eff = (out_cfg[k].pulse_sec == 6'h00) ? 1 : out_cfg[k].pulse_sec;
      drive0(1'b1, 5);
      `CMP(relay_out[k], ~act)
      drive0(1'b0, 3);
      out_cfg[k].en = 1'b1;
      tick(3);
      `CMP(relay_out[k], ~act)
      rec_acc = 4'h0;
      drive0(1'b1, 5);
      `CMP(relay_out[k], act)
      `CMP(rec_acc, in_cfg[0].rec_mask)
      drive0(1'b0, 4);
      if (m < 2)
        `CMP(relay_out[k], ~act)
      else if (m < 4)
      begin
        `CMP(relay_out[k], act)
        drive0(1'b1, 4);
        `CMP(relay_out[k], ~act)
        drive0(1'b0, 1);
      end
      else
      begin
        tick(SEC * eff - 13);
        `CMP(relay_out[k], act)
        tick(SEC + 30);
        `CMP(relay_out[k], ~act)
      end
    end
    // Plain open relay from here on
    out_cfg[k].mode = aio_pkg::AIO_OUT_OPEN;
    in_cfg[0].latch = 1'b1;
    drive0(1'b1, 5);
    `CMP(relay_out[k], 1'b0)
    drive0(1'b0, 3);
    in_cfg[0].latch = 1'b0;
    mon_en = 1'b0;
    rec_acc = 4'h0;
    drive0(1'b1, 5);
    `CMP(relay_out[k], 1'b0)
    `CMP(rec_acc, 4'h0)
    drive0(1'b0, 3);
    in_cfg[0].en = 1'b0;
    mon_en = 1'b1;
    drive0(1'b1, 5);
    `CMP(relay_out[k], 1'b0)
    in_cfg[0].idle_gnd = 1'b1;
    in_cfg[0].en = 1'b1;
    tick(4);
    `CMP(relay_out[k], 1'b0)
    drive0(1'b0, 4);
    `CMP(relay_out[k], 1'b1)
    mon_en = 1'b0;
    in_cfg[0].idle_gnd = 1'b0;
    tick(3);
    mon_en = 1'b1;
    // Each alarm source on its own
    j = rnd() % 4;
    for (int s = 0; s < 4; s++)
    begin
      out_cfg[k].vloss_sel[j] = (s == 0);
      out_cfg[k].tamper_sel[j] = (s == 1);
      out_cfg[k].wr_err_sel = (s == 2);
      out_cfg[k].full_sel = (s == 3);
      video_loss[j] = (s == 0);
      tamper[j] = (s == 1);
      {write_err, storage_full} = {s == 2, s == 3};
      tick(4);
      `CMP(relay_out[k], 1'b1)
      {video_loss, tamper, write_err, storage_full} = '0;
      tick(4);
      `CMP(relay_out[k], 1'b0)
    end
    // Preset move on activation, off-move after the hold
    c = 2'(rnd());
    on_p = 8'(rnd());
    off_p = ~on_p;
    in_cfg[1] = '0;
    {in_cfg[1].en, in_cfg[1].ptz_en, in_cfg[1].cam} = {2'b11, c};
    {in_cfg[1].on_preset, in_cfg[1].off_preset, in_cfg[1].hold_sec} = {on_p, off_p, 8'h02};
    alarm_in[1] = 1'b1;
    watch(1, 8, 1'b1, n);
    `CMP(ptz_cmd.preset, on_p)
    `CMP(ptz_cmd.cam, c)
    `CMP(ptz_cmd.link, cam_cfg[c])
    alarm_in[1] = 1'b0;
    watch(1, 90, 1'b1, n);
    `CMP(ptz_cmd.preset, off_p)
    `CMP(n >= 2 * SEC - 2 && n <= 3 * SEC + 6, 1'b1)
    // Reader frames: two good lengths, a bad one, one while GPS owns the port
    lens = '{26, 37, 30, 26};
    aux_mode = aio_pkg::AIO_AUX_WIEG;
    for (int i = 0; i < 4; i++)
    begin
      bits = 37'({rnd(), rnd()});
      card_fwd_en = 1'(rnd());
      aux_mode = (i == 3) ? aio_pkg::AIO_AUX_GPS : aio_pkg::AIO_AUX_WIEG;
      rec_acc = 4'h0;
      fork
        aio_partner_inst.send_card(bits, lens[i]);
        watch(3, 400, 1'b0, n);
      join
      `CMP(seen, i < 2)
      if (i < 2)
      begin
        `CMP(card_num, exp_num(bits, lens[i]))
        `CMP(card_len37, lens[i] == 37)
        `CMP(fwd_at, card_fwd_en)
        `CMP(rec_acc, wieg_rec_mask)
      end
    end
    // GPS capture: window, bytes at both rates, close on line feed, refusal
    watch(4, 700, 1'b1, n);
    gps(8'h47);
    `CMP(seen, 1'b1)
    `CMP(gps_byte, 8'h47)
    gps(aio_pkg::AIO_GPS_EOL);
    `CMP(win_after, 1'b0)
    watch(4, 700, 1'b1, n);
    gps_baud_slow = 1'b1;
    gps(8'h33);
    `CMP(gps_byte, 8'h33)
    gps_baud_slow = 1'b0;
    aux_mode = aio_pkg::AIO_AUX_WIEG;
    gps(8'h55);
    `CMP(seen, 1'b0)
    give_verdict();
  end
endmodule
